// ==== timer_two_pkg.sv ====
/*
 * Constants, field positions and helpers shared by the second auto-reload timer.
 * Assumes a single system clock domain and the special function register port of the top.
 */
package timer_two_pkg;

    localparam logic [7:0] ADDR_CONTROL = 8'hC8;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;

    localparam int BIT_HIGH_FLAG = 7;
    localparam int BIT_LOW_FLAG = 6;
    localparam int BIT_LOW_IRQ_EN = 5;
    localparam int BIT_CAPTURE_EN = 4;
    localparam int BIT_SPLIT = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_EXT_CLK = 0;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] CONTROL_WRITE_MASK = 8'hFD;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    localparam int SYS_DIVIDE = 12;
    localparam int EXT_DIVIDE = 8;

    // Fast select wins; otherwise the external select picks the slow source
    function automatic logic pick_tick(input logic fast, input logic ext_sel,
                                       input logic div12, input logic ext8);
        pick_tick = fast ? 1'b1 : (ext_sel ? ext8 : div12);
    endfunction

endpackage

// ==== tick_if.sv ====
/*
 * Carries the divided count ticks from the tick generator to the timer core.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface tick_if;
    logic div12_tick;
    logic ext8_tick;
    modport src (output div12_tick, output ext8_tick);
    modport dst (input div12_tick, input ext8_tick);
endinterface
`default_nettype wire

// ==== tick_gen.sv ====
/*
 * Makes one-cycle ticks at the system clock divided by 12 and at the
 * external oscillator divided by 8, the latter synchronised first.
 * Assumes the external oscillator is well below half the system clock rate.
 */
`timescale 1ns/100ps
`default_nettype none
module tick_gen #(
    parameter int SYS_DIV = timer_two_pkg::SYS_DIVIDE,
    parameter int EXT_DIV = timer_two_pkg::EXT_DIVIDE
) (
    input wire logic mclk,      // system clock
    input wire logic rst_b,     // sync reset, active low
    input wire logic ext_osc,   // external oscillator pin
    tick_if.src ticks           // divided ticks
);
    import timer_two_pkg::*;

    logic [3:0] sys_cnt_ff, nxt_sys_cnt;
    logic [2:0] ext_sync_ff, nxt_ext_sync;
    logic ext_level_ff, nxt_ext_level;
    logic [2:0] ext_cnt_ff, nxt_ext_cnt;
    logic div12_ff, nxt_div12;
    logic ext8_ff, nxt_ext8;
    logic ext_rise;

    always_comb begin
        nxt_ext_sync = {ext_sync_ff[1:0], ext_osc};
        nxt_ext_level = ext_level_ff;
        ext_rise = 1'b0;
        // Only the second and third stages are looked at
        if (ext_sync_ff[1] == ext_sync_ff[2]) begin
            nxt_ext_level = ext_sync_ff[2];
            ext_rise = ext_sync_ff[2] && !ext_level_ff;
        end
        nxt_div12 = 1'b0;
        nxt_sys_cnt = sys_cnt_ff + 4'h1;
        if (sys_cnt_ff == 4'(SYS_DIV - 1)) begin
            nxt_sys_cnt = 4'h0;
            nxt_div12 = 1'b1;
        end
        nxt_ext8 = 1'b0;
        nxt_ext_cnt = ext_cnt_ff;
        if (ext_rise) begin
            nxt_ext_cnt = ext_cnt_ff + 3'h1;
            nxt_ext8 = (ext_cnt_ff == 3'(EXT_DIV - 1));
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sys_cnt_ff <= 4'h0;
            ext_sync_ff <= 3'h0;
            ext_level_ff <= 1'b0;
            ext_cnt_ff <= 3'h0;
            div12_ff <= 1'b0;
            ext8_ff <= 1'b0;
        end else begin
            sys_cnt_ff <= nxt_sys_cnt;
            ext_sync_ff <= nxt_ext_sync;
            ext_level_ff <= nxt_ext_level;
            ext_cnt_ff <= nxt_ext_cnt;
            div12_ff <= nxt_div12;
            ext8_ff <= nxt_ext8;
        end
    end

    assign ticks.div12_tick = div12_ff;
    assign ticks.ext8_tick = ext8_ff;
endmodule
`default_nettype wire

// ==== count_byte.sv ====
/*
 * One 8-bit count byte: software write, increment, wrap or reload.
 * Assumes the caller decides when a wrap reloads and when it rolls to zero.
 */
`timescale 1ns/100ps
`default_nettype none
module count_byte #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,                   // system clock
    input wire logic rst_b,                  // sync reset, active low
    input wire logic inc,                    // advance by one
    input wire logic reload_on_wrap,         // a wrap loads reload_val
    input wire logic [WIDTH-1:0] reload_val, // value loaded on wrap
    input wire logic wr_en,                  // software write
    input wire logic [WIDTH-1:0] wr_data,    // software data
    output logic [WIDTH-1:0] count,          // current count
    output logic wrap                        // all ones and advancing
);
    logic [WIDTH-1:0] count_ff, nxt_count;

    always_comb begin
        wrap = inc && (count_ff == {WIDTH{1'b1}});
        nxt_count = count_ff;
        if (wr_en) begin
            // Software write beats a tick in the same cycle
            nxt_count = wr_data;
        end else if (wrap && reload_on_wrap) begin
            nxt_count = reload_val;
        end else if (inc) begin
            nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            count_ff <= {WIDTH{1'b0}};
        end else begin
            count_ff <= nxt_count;
        end
    end

    assign count = count_ff;
endmodule
`default_nettype wire

// ==== auto_reload_timer_two.sv ====
/*
 * Second timer: two count bytes and two reload bytes working as one 16-bit
 * auto-reload counter or as two 8-bit auto-reload counters, with sticky
 * overflow flags, interrupt request and low-frequency oscillator capture.
 * Assumes a one-cycle special function register port on the system clock;
 * the global timer interrupt enable and the two fast-clock selects live in
 * registers outside and arrive as levels.
 */
// Notes on behaviour
// - Count kept as low and high bytes
// - Control bit 3 picks split or 16-bit
// - Sources: sysclk, sysclk/12, synchronised external/8
// - 16-bit wrap loads both reload bytes
// - 16-bit overflow sets high overflow flag
// - Timer enable requests interrupt per overflow
// - Low-byte enable adds low-byte wrap interrupts
// - Split mode: two independent 8-bit reloads
// - Split mode: run gates only high byte
// - Fast select, else external select picks source
// - Split wraps set high and low flags
// - Split interrupts: high, or either with enable
// - Flags cleared only by software writes
// - Capture copies count to reload, interrupts
`timescale 1ns/100ps
`default_nettype none
module auto_reload_timer_two (
    input wire logic mclk,                        // system clock, 100 MHz
    input wire logic rst_b,                       // sync reset, active low
    input wire logic [7:0] sfr_addr,              // register address
    input wire logic sfr_wr,                      // write strobe
    input wire logic [7:0] sfr_wdata,             // write data
    input wire logic sfr_rd,                      // read strobe
    output logic [7:0] sfr_rdata,                 // read data, next cycle
    input wire logic timer_irq_enable,            // global timer interrupt enable
    input wire logic high_byte_fast_clock_select, // high byte on system clock
    input wire logic low_byte_fast_clock_select,  // low byte on system clock
    input wire logic ext_osc_in,                  // external oscillator pin
    input wire logic lfo_in,                      // low-frequency oscillator pin
    output logic irq_req                          // interrupt request level
);
    import timer_two_pkg::*;

    tick_if ticks ();

    logic [7:0] control_ff, nxt_control;
    logic [7:0] reload_low_ff, nxt_reload_low;
    logic [7:0] reload_high_ff, nxt_reload_high;
    logic [7:0] rdata_ff, nxt_rdata;
    logic irq_ff, nxt_irq;
    logic [2:0] lfo_sync_ff, nxt_lfo_sync;
    logic lfo_level_ff, nxt_lfo_level;

    logic [7:0] low_count_byte, high_count_byte;
    logic low_wrap, high_wrap;
    logic low_inc, high_inc;
    logic low_reload_on_wrap, high_reload_on_wrap;
    logic low_wr, high_wr;
    logic ctl_wr;
    logic reload_low_wr, reload_high_wr;
    logic low_tick, high_tick;
    logic split_mode_select, run_control, external_clock_select;
    logic low_byte_irq_enable, lfo_capture_enable;
    logic high_overflow_flag, low_overflow_flag;
    logic overflow_16, lfo_fall, capture;
    logic set_high_flag, set_low_flag;

    tick_gen u_tick_gen (
        .mclk (mclk),
        .rst_b (rst_b),
        .ext_osc (ext_osc_in),
        .ticks (ticks.src)
    );

    // Shared register decode; an unmapped address matches no strobe
    function automatic logic hit(input logic strobe, input logic [7:0] addr,
                                 input logic [7:0] target);
        hit = strobe && (addr == target);
    endfunction

    // Control fields
    always_comb begin
        high_overflow_flag = control_ff[BIT_HIGH_FLAG];
        low_overflow_flag = control_ff[BIT_LOW_FLAG];
        low_byte_irq_enable = control_ff[BIT_LOW_IRQ_EN];
        lfo_capture_enable = control_ff[BIT_CAPTURE_EN];
        split_mode_select = control_ff[BIT_SPLIT];
        run_control = control_ff[BIT_RUN];
        external_clock_select = control_ff[BIT_EXT_CLK];
    end

    // Clock source per byte
    always_comb begin
        low_tick = pick_tick(low_byte_fast_clock_select, external_clock_select,
                             ticks.div12_tick, ticks.ext8_tick);
        high_tick = pick_tick(high_byte_fast_clock_select, external_clock_select,
                              ticks.div12_tick, ticks.ext8_tick);
    end

    // Count enables and reload steering for the two modes
    always_comb begin
        if (split_mode_select) begin
            low_inc = low_tick;
            high_inc = high_tick && run_control;
            low_reload_on_wrap = 1'b1;
            high_reload_on_wrap = 1'b1;
            overflow_16 = 1'b0;
        end else begin
            // The high byte only moves on the low byte's carry
            low_inc = low_tick && run_control;
            // Carry decoded from the counts, not the wraps, so no path loops back
            high_inc = low_inc && (low_count_byte == BYTE_ALL_ONES);
            overflow_16 = high_inc && (high_count_byte == BYTE_ALL_ONES);
            low_reload_on_wrap = overflow_16;
            high_reload_on_wrap = 1'b1;
        end
    end

    // Register write strobes
    always_comb begin
        ctl_wr = hit(sfr_wr, sfr_addr, ADDR_CONTROL);
        reload_low_wr = hit(sfr_wr, sfr_addr, ADDR_RELOAD_LOW);
        reload_high_wr = hit(sfr_wr, sfr_addr, ADDR_RELOAD_HIGH);
        // Count strobes go to the bytes, where a write beats a tick
        low_wr = hit(sfr_wr, sfr_addr, ADDR_COUNT_LOW);
        high_wr = hit(sfr_wr, sfr_addr, ADDR_COUNT_HIGH);
    end

    count_byte #(
        .WIDTH (8)
    ) u_low_byte (
        .mclk (mclk),
        .rst_b (rst_b),
        .inc (low_inc),
        .reload_on_wrap (low_reload_on_wrap),
        .reload_val (reload_low_ff),
        .wr_en (low_wr),
        .wr_data (sfr_wdata),
        .count (low_count_byte),
        .wrap (low_wrap)
    );

    count_byte #(
        .WIDTH (8)
    ) u_high_byte (
        .mclk (mclk),
        .rst_b (rst_b),
        .inc (high_inc),
        .reload_on_wrap (high_reload_on_wrap),
        .reload_val (reload_high_ff),
        .wr_en (high_wr),
        .wr_data (sfr_wdata),
        .count (high_count_byte),
        .wrap (high_wrap)
    );

    // Low-frequency oscillator: three stages, change taken once two agree
    always_comb begin
        nxt_lfo_sync = {lfo_sync_ff[1:0], lfo_in};
        nxt_lfo_level = lfo_level_ff;
        lfo_fall = 1'b0;
        if (lfo_sync_ff[1] == lfo_sync_ff[2]) begin
            nxt_lfo_level = lfo_sync_ff[2];
            lfo_fall = lfo_level_ff && !lfo_sync_ff[2];
        end
        // Needs the global enable too, so a masked timer never captures
        capture = lfo_fall && lfo_capture_enable && timer_irq_enable;
    end

    // Stages start low: a pin resting high shows a rise, never a false fall
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            lfo_sync_ff <= 3'h0;
            lfo_level_ff <= 1'b0;
        end else begin
            lfo_sync_ff <= nxt_lfo_sync;
            lfo_level_ff <= nxt_lfo_level;
        end
    end

    // Flag set events
    always_comb begin
        if (split_mode_select) begin
            set_high_flag = high_wrap;
        end else begin
            set_high_flag = overflow_16;
        end
        // Capture reports through the high flag so software sees a source
        set_high_flag = set_high_flag || capture;
        // Low flag tracks low-byte wraps in either mode
        set_low_flag = low_wrap;
    end

    // Control register: software write first, hardware flag sets on top
    always_comb begin
        nxt_control = control_ff;
        if (ctl_wr) begin
            // Flags only fall by this write path
            // Bit 1 has no storage; the mask keeps it zero
            nxt_control = sfr_wdata & CONTROL_WRITE_MASK;
        end
        // Hardware set beats a software clear in the same cycle
        if (set_high_flag) begin
            nxt_control[BIT_HIGH_FLAG] = 1'b1;
        end
        if (set_low_flag) begin
            nxt_control[BIT_LOW_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            control_ff <= CONTROL_RESET;
        end else begin
            control_ff <= nxt_control;
        end
    end

    // Reload bytes: software writes, overridden by a capture
    always_comb begin
        nxt_reload_low = reload_low_ff;
        nxt_reload_high = reload_high_ff;
        if (reload_low_wr) begin
            nxt_reload_low = sfr_wdata;
        end
        if (reload_high_wr) begin
            nxt_reload_high = sfr_wdata;
        end
        // Capture wins over a software reload write in the same cycle
        if (capture) begin
            nxt_reload_low = low_count_byte;
            nxt_reload_high = high_count_byte;
        end
    end

    // Reload bytes keep their value across mode changes
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            reload_low_ff <= BYTE_RESET;
            reload_high_ff <= BYTE_RESET;
        end else begin
            reload_low_ff <= nxt_reload_low;
            reload_high_ff <= nxt_reload_high;
        end
    end

    // Interrupt request follows the high flag, and the low flag when bit 5 enables it, while the global enable is high, so it holds until cleared or the enable falls
    always_comb begin
        nxt_irq = 1'b0;
        if (timer_irq_enable) begin
            nxt_irq = nxt_control[BIT_HIGH_FLAG];
            if (nxt_control[BIT_LOW_IRQ_EN]) begin
                nxt_irq = nxt_irq || nxt_control[BIT_LOW_FLAG];
            end
        end
    end

    // Registered so the request pin cannot glitch while flags update
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    // Count bytes are read one at a time; a running count may carry between
    // the two reads, so software should stop the timer or read twice
    // Read path, registered; unused bit 1 reads zero
    always_comb begin
        nxt_rdata = rdata_ff;
        if (sfr_rd) begin
            if (sfr_addr == ADDR_CONTROL) begin
                nxt_rdata = control_ff & CONTROL_WRITE_MASK;
            end else if (sfr_addr == ADDR_RELOAD_LOW) begin
                nxt_rdata = reload_low_ff;
            end else if (sfr_addr == ADDR_RELOAD_HIGH) begin
                nxt_rdata = reload_high_ff;
            end else if (sfr_addr == ADDR_COUNT_LOW) begin
                nxt_rdata = low_count_byte;
            end else if (sfr_addr == ADDR_COUNT_HIGH) begin
                nxt_rdata = high_count_byte;
            end else begin
                nxt_rdata = UNMAPPED_READ;
            end
        end
    end

    // Held between reads, so software may pick it up late
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rdata_ff <= BYTE_RESET;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign sfr_rdata = rdata_ff;
    assign irq_req = irq_ff;
endmodule
`default_nettype wire

// ==== timer_two_sva.sv ====
/* Port checker for the second timer.
   Assumes only the top's ports; bound after the module. */
`timescale 1ns/100ps
`default_nettype none
module timer_two_sva
    import timer_two_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic rst_b, // reset
    input wire logic [7:0] sfr_addr, // address
    input wire logic sfr_wr, // write
    input wire logic [7:0] sfr_wdata, // data in
    input wire logic sfr_rd, // read
    input wire logic [7:0] sfr_rdata, // data out
    input wire logic timer_irq_enable, // enable
    input wire logic irq_req // request
);
    logic mapped;
    logic ctl_wr;
    assign mapped = sfr_addr inside {ADDR_CONTROL, ADDR_RELOAD_LOW, ADDR_RELOAD_HIGH,
        ADDR_COUNT_LOW, ADDR_COUNT_HIGH};
    assign ctl_wr = sfr_wr && sfr_addr == ADDR_CONTROL;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_b |=> !irq_req && sfr_rdata == 8'h00) else $error("reset left outputs set");
    a_irq_gated: assert property (
        !timer_irq_enable |=> !irq_req) else $error("request without enable");
    a_irq_sticky: assert property (
        irq_req && timer_irq_enable && !ctl_wr |=> irq_req) else $error("request dropped");
    a_rd_hold: assert property (
        !sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved");
    a_bit1_zero: assert property (
        sfr_rd && sfr_addr == ADDR_CONTROL |=> !sfr_rdata[1]) else $error("bit 1 read 1");
    a_unmapped_zero: assert property (
        sfr_rd && !mapped |=> sfr_rdata == UNMAPPED_READ) else $error("unmapped read");
    // Global enable low: no capture can overwrite the reload byte meanwhile
    a_reload_back: assert property (
        sfr_wr && sfr_addr == ADDR_RELOAD_HIGH && !timer_irq_enable
        ##1 !sfr_wr && !timer_irq_enable ##1 sfr_rd
        && sfr_addr == ADDR_RELOAD_HIGH |=> sfr_rdata == $past(sfr_wdata, 3))
        else $error("reload byte lost");
    a_ctrl_back: assert property (
        ctl_wr ##1 !sfr_wr ##1 sfr_rd && sfr_addr == ADDR_CONTROL
        |=> (sfr_rdata & 8'h3D) == ($past(sfr_wdata, 3) & 8'h3D))
        else $error("control bits lost");
    c_irq: cover property ($rose(irq_req));
    c_unmapped: cover property (sfr_rd && !mapped);
    c_split: cover property (ctl_wr && sfr_wdata[BIT_SPLIT]);
endmodule
bind auto_reload_timer_two timer_two_sva chk (.mclk(mclk), .rst_b(rst_b),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .timer_irq_enable(timer_irq_enable), .irq_req(irq_req));
`default_nettype wire

// ==== auto_reload_timer_two_test.sv ====
/* Self-checking bench for the second timer.
   Assumes fast-select pulses clock the bytes; ext mode with a still pin freezes them. */
`timescale 1ns/100ps
`default_nettype none
module auto_reload_timer_two_test;
    logic mclk, rst_b, wr_s, rd_s, en, hfast, lfast, ext_osc, lfo;
    logic [7:0] addr, wdata;
    logic [7:0] rdata;
    logic irq;
    int n_errors, num_checks;
    auto_reload_timer_two uut (.mclk(mclk), .rst_b(rst_b), .sfr_addr(addr), .sfr_wr(wr_s),
        .sfr_wdata(wdata), .sfr_rd(rd_s), .sfr_rdata(rdata), .timer_irq_enable(en),
        .high_byte_fast_clock_select(hfast), .low_byte_fast_clock_select(lfast),
        .ext_osc_in(ext_osc), .lfo_in(lfo), .irq_req(irq));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        wr_s = 1'b1;
        addr = a;
        wdata = d;
        @(negedge mclk);
        wr_s = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        rd_s = 1'b1;
        addr = a;
        @(negedge mclk);
        rd_s = 1'b0;
        chk($sformatf("reg %h", a), e, rdata);
    endtask
    // Fast select held for n edges; ext mode keeps the byte still otherwise
    task automatic pulse(input bit hi, input int n);
        @(negedge mclk);
        if (hi) hfast = 1'b1; else lfast = 1'b1;
        repeat (n) @(negedge mclk);
        hfast = 1'b0;
        lfast = 1'b0;
    endtask
    logic [7:0] uut_regs [6] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC9};
    task automatic t_reset();
        foreach (uut_regs[i]) rd(uut_regs[i], 8'h00);
        chk("irq", 8'h00, {7'h0, irq});
        wr(8'hC8, 8'h3F);
        rd(8'hC8, 8'h3D);
        wr(8'hC8, 8'h00);
        wr(8'hCB, 8'h5A);
        rd(8'hCB, 8'h5A);
        wr(8'hC9, 8'hFF);
        rd(8'hC9, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_wrap16();
        en = 1'b1;
        wr(8'hCC, 8'hFE);
        wr(8'hCD, 8'hFF);
        wr(8'hCA, 8'h34);
        wr(8'hCB, 8'h12);
        wr(8'hC8, 8'h05);
        pulse(0, 2);
        rd(8'hCC, 8'h34);
        rd(8'hCD, 8'h12);
        rd(8'hC8, 8'hC5);
        chk("irq", 8'h01, {7'h0, irq});
        wr(8'hC8, 8'h00);
        rd(8'hC8, 8'h00);
        chk("irq", 8'h00, {7'h0, irq});
        $display("test wrap16 done");
    endtask
    task automatic t_carry();
        wr(8'hCC, 8'hFF);
        wr(8'hCD, 8'h00);
        wr(8'hC8, 8'h05);
        pulse(0, 2);
        rd(8'hCC, 8'h01);
        rd(8'hCD, 8'h01);
        rd(8'hC8, 8'h45);
        chk("irq", 8'h00, {7'h0, irq});
        wr(8'hC8, 8'h25);
        chk("irq", 8'h00, {7'h0, irq});
        wr(8'hCC, 8'hFF);
        pulse(0, 1);
        rd(8'hCD, 8'h02);
        rd(8'hC8, 8'h65);
        chk("irq", 8'h01, {7'h0, irq});
        wr(8'hC8, 8'h00);
        $display("test carry done");
    endtask
    task automatic t_split();
        wr(8'hCC, 8'hFE);
        wr(8'hCD, 8'h10);
        wr(8'hCA, 8'h80);
        wr(8'hCB, 8'h90);
        wr(8'hC8, 8'h09);
        pulse(0, 2);
        pulse(1, 3);
        rd(8'hCC, 8'h80);
        rd(8'hCD, 8'h10);
        rd(8'hC8, 8'h49);
        chk("irq", 8'h00, {7'h0, irq});
        wr(8'hCD, 8'hFF);
        wr(8'hC8, 8'h0D);
        pulse(1, 1);
        rd(8'hCD, 8'h90);
        rd(8'hCC, 8'h80);
        rd(8'hC8, 8'h8D);
        chk("irq", 8'h01, {7'h0, irq});
        wr(8'hC8, 8'h29);
        chk("irq", 8'h00, {7'h0, irq});
        wr(8'hCC, 8'hFF);
        pulse(0, 1);
        rd(8'hCC, 8'h80);
        chk("irq", 8'h01, {7'h0, irq});
        wr(8'hC8, 8'h00);
        $display("test split done");
    endtask
    task automatic t_sources();
        wr(8'hCC, 8'h00);
        wr(8'hCD, 8'h00);
        wr(8'hC8, 8'h04);
        repeat (238) @(negedge mclk);
        wr(8'hC8, 8'h05);
        rd(8'hCC, 8'h14);
        wr(8'hCC, 8'h00);
        repeat (40) begin
            ext_osc = 1'b1;
            repeat (2) @(negedge mclk);
            ext_osc = 1'b0;
            repeat (2) @(negedge mclk);
        end
        repeat (10) @(negedge mclk);
        wr(8'hC8, 8'h01);
        rd(8'hCC, 8'h05);
        $display("test sources done");
    endtask
    task automatic t_capture();
        wr(8'hCC, 8'h78);
        wr(8'hCD, 8'h56);
        wr(8'hC8, 8'h11);
        lfo = 1'b0;
        repeat (8) @(negedge mclk);
        rd(8'hCA, 8'h78);
        rd(8'hCB, 8'h56);
        rd(8'hC8, 8'h91);
        chk("irq", 8'h01, {7'h0, irq});
        $display("test capture done");
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        {rst_b, wr_s, rd_s, en, hfast, lfast, ext_osc} = '0;
        {addr, wdata} = '0;
        lfo = 1'b1;
        repeat (6) @(negedge mclk);
        rst_b = 1'b1;
        t_reset();
        t_wrap16();
        t_carry();
        t_split();
        t_sources();
        t_capture();
        wrap_up();
    end
    initial begin
        #100000;
        n_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
